// ===== logic/flash_cmd_pkg.sv
// Purpose: shared constants, types and helpers of the serial flash command block
// Assumes: system clock far faster than the serial clock (200 MHz against 6.25 MHz)
// Notes: lane widths are carried as 1, 2 or 4 data lines per serial clock
package flash_cmd_pkg;

  // opcodes
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_SET_WRAP = 8'h77;
  localparam logic [7:0] OP_PAGE_PROGRAM = 8'h02;
  localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
  localparam logic [7:0] OP_CONT_READ_RESET = 8'hff;

  // lane widths, clocks per phase
  localparam logic [2:0] LANE1 = 3'h1;
  localparam logic [2:0] LANE2 = 3'h2;
  localparam logic [2:0] LANE4 = 3'h4;
  localparam logic [3:0] FAST_READ_DUMMY = 4'h8;
  localparam logic [3:0] QUAD_IO_SPI_DUMMY = 4'h4;
  localparam logic [3:0] DUAL_IO_MODE_CLOCKS = 4'h4;
  localparam logic [3:0] QUAD_IO_MODE_CLOCKS = 4'h2;
  localparam logic [3:0] QPI_DUMMY_P0 = 4'h4;
  localparam logic [3:0] QPI_DUMMY_P1 = 4'h4;
  localparam logic [3:0] QPI_DUMMY_P2 = 4'h6;
  localparam logic [3:0] QPI_DUMMY_P3 = 4'h8;

  // continuous-read trigger and reset values
  localparam logic [1:0] CONT_KEEP_CODE = 2'h2;
  localparam logic [7:0] CONT_BITS_RESET = 8'h00;
  localparam logic [2:0] WRAP_SETTING_RESET = 3'h1;
  localparam int WRAP_DISABLE_POS = 0;
  localparam logic [7:0] PAGE_LAST_COL = 8'hff;

  // timing of the self-timed program cycle
  localparam int unsigned CLK_PERIOD_PS = 5000;
  localparam int unsigned PROG_TIME_NS = 600000;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_CMD = 4'h1,
    ST_ADDR = 4'h2,
    ST_MODE = 4'h3,
    ST_DUMMY = 4'h4,
    ST_OUT = 4'h5,
    ST_PROG = 4'h6,
    ST_WRAP = 4'h7,
    ST_SKIP = 4'h8
  } cmd_state_t;

  typedef struct packed {
    logic [2:0] addr_w;
    logic [2:0] out_w;
    logic [3:0] mode_len;
    logic [3:0] dummy_len;
  } read_cfg_t;

  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic [3:0] io;
  } pin_set_t;

  localparam pin_set_t PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, io: 4'h0};

  typedef struct packed {
    logic en;
    logic [23:0] addr;
    logic [7:0] data;
  } mem_wr_t;

  function automatic logic [31:0] shift_in(logic [31:0] sh, logic [3:0] io, logic [2:0] w);
    case (w)
      LANE2: shift_in = {sh[29:0], io[1:0]};
      LANE4: shift_in = {sh[27:0], io[3:0]};
      default: shift_in = {sh[30:0], io[0]};
    endcase
  endfunction : shift_in

  function automatic logic [5:0] byte_clocks(logic [2:0] w);
    case (w)
      LANE2: byte_clocks = 6'd4;
      LANE4: byte_clocks = 6'd2;
      default: byte_clocks = 6'd8;
    endcase
  endfunction : byte_clocks

  function automatic logic [5:0] addr_clocks(logic [2:0] w);
    addr_clocks = 6'(byte_clocks(w) * 6'd3);
  endfunction : addr_clocks

  function automatic logic [3:0] qpi_dummy(logic [1:0] field);
    case (field)
      2'h0: qpi_dummy = QPI_DUMMY_P0;
      2'h1: qpi_dummy = QPI_DUMMY_P1;
      2'h2: qpi_dummy = QPI_DUMMY_P2;
      default: qpi_dummy = QPI_DUMMY_P3;
    endcase
  endfunction : qpi_dummy

  function automatic read_cfg_t read_config(logic [7:0] op, logic four_line_command_mode, logic [1:0] field);
    case (op)
      OP_DUAL_OUT_READ: read_config = '{LANE1, LANE2, 4'h0, FAST_READ_DUMMY};
      OP_QUAD_OUT_READ: read_config = '{LANE1, LANE4, 4'h0, FAST_READ_DUMMY};
      OP_DUAL_IO_READ: read_config = '{LANE2, LANE2, DUAL_IO_MODE_CLOCKS, 4'h0};
      OP_QUAD_IO_READ: read_config = '{LANE4, LANE4, QUAD_IO_MODE_CLOCKS,
          four_line_command_mode ? 4'(qpi_dummy(field) - QUAD_IO_MODE_CLOCKS) : QUAD_IO_SPI_DUMMY};
      default: read_config = '{LANE1, LANE1, 4'h0, 4'h0};
    endcase
  endfunction : read_config

  // read address step, wrapping inside an aligned 8/16/32/64-byte section when asked
  function automatic logic [23:0] next_read_addr(logic [23:0] a, logic wrap, logic [1:0] len);
    logic [5:0] mask;
    logic [23:0] inc;
    mask = 6'(({1'b0, 6'h08} << len) - 7'h01);
    inc = a + 24'h000001;
    if (wrap) begin
      next_read_addr = (a & ~{18'h0, mask}) | (inc & {18'h0, mask});
    end else begin
      next_read_addr = inc;
    end
  endfunction : next_read_addr

  // protected 64 KiB blocks: count from field bits 2..0, bit 3 picks the bottom end
  function automatic logic page_protected(logic [3:0] blk, logic [4:0] bp);
    logic [4:0] n;
    n = (bp[2:0] == 3'h0) ? 5'h00 : ((bp[2:0] >= 3'h5) ? 5'h10 : 5'(5'h01 << (bp[2:0] - 3'h1)));
    if (bp[3]) begin
      page_protected = {1'b0, blk} < n;
    end else begin
      page_protected = {1'b0, blk} >= (5'h10 - n);
    end
  endfunction : page_protected

endpackage : flash_cmd_pkg

// ===== logic/pin_sampler.sv
// Purpose: bring chip select, serial clock and data lines into the system clock
// Assumes: all pins are asynchronous to i_clk
// Notes: a bit changes only once the second and third stages agree
`timescale 1ns/1ps
`default_nettype none
module pin_sampler
  import flash_cmd_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire pin_set_t i_pins,
  output pin_set_t o_pins
);

  pin_set_t s1;
  pin_set_t s2;
  pin_set_t s3;
  wire pin_set_t agree = pin_set_t'(~(s2 ^ s3));

  // three-stage chain; the first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1 <= PINS_IDLE;
      s2 <= PINS_IDLE;
      s3 <= PINS_IDLE;
      o_pins <= PINS_IDLE;
    end else begin
      s1 <= i_pins;
      s2 <= s1;
      s3 <= s2;
      o_pins <= pin_set_t'((s2 & agree) | (o_pins & ~agree));
    end
  end

endmodule : pin_sampler
`default_nettype wire

// ===== logic/page_program_engine.sv
// Purpose: page buffer and self-timed program cycle
// Assumes: PROG_CYCLES well above 257 so the page walk ends before the cycle
// Notes: only bytes received in the frame are written; the rest of the page stays
`timescale 1ns/1ps
`default_nettype none
module page_program_engine
  import flash_cmd_pkg::*;
#(
  parameter int unsigned PROG_CYCLES = 1000
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_clear,
  input wire logic i_store,
  input wire logic [7:0] i_col,
  input wire logic [7:0] i_byte,
  input wire logic i_start,
  input wire logic [15:0] i_page,
  output logic o_busy,
  output logic o_done,
  output mem_wr_t o_mem_wr
);

  logic [7:0] page_buf [256];
  logic [255:0] written;
  logic [7:0] idx;
  logic walking;
  logic [31:0] timer;
  logic [15:0] page;

  // later bytes to the same column overwrite earlier ones
  always_ff @(posedge i_clk) begin
    if (i_store) begin
      page_buf[i_col] <= i_byte;
    end
  end

  // mask of touched columns
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      written <= '0;
    end else if (i_clear) begin
      written <= '0;
    end else if (i_store) begin
      written[i_col] <= 1'b1;
    end
  end

  // cycle timer; done pulses one cycle before busy falls
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_busy <= 1'b0;
      o_done <= 1'b0;
      timer <= '0;
      page <= '0;
    end else begin
      o_done <= o_busy && (timer == 32'd1);
      if (!o_busy && i_start) begin
        o_busy <= 1'b1;
        timer <= PROG_CYCLES - 32'd1;
        page <= i_page;
      end else if (o_busy) begin
        timer <= timer - 32'd1;
        o_busy <= (timer != 32'd0);
      end
    end
  end

  // walk the page once, writing touched columns only
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      walking <= 1'b0;
      idx <= '0;
      o_mem_wr <= '0;
    end else begin
      o_mem_wr.en <= walking && written[idx];
      o_mem_wr.addr <= {page, idx};
      o_mem_wr.data <= page_buf[idx];
      if (!o_busy && i_start) begin
        walking <= 1'b1;
        idx <= '0;
      end else if (walking) begin
        idx <= idx + 8'h01;
        walking <= (idx != PAGE_LAST_COL);
      end
    end
  end

endmodule : page_program_engine
`default_nettype wire

// ===== logic/flash_cmd_engine.sv
// Purpose: serial flash command interpreter for multi-line reads, wrap and page program
// Assumes: memory read data is valid one i_clk after o_mem_rd_addr changes
// Notes: the serial clock is sampled; data is taken on its rise and driven on its fall
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_engine
  import flash_cmd_pkg::*;
#(
  parameter int unsigned PROG_TIME = PROG_TIME_NS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_sclk,
  input wire logic [3:0] i_io_in,
  output logic [3:0] o_io_out,
  output logic [3:0] o_io_oe,
  input wire logic i_quad_io_enable,
  input wire logic i_four_line_command_mode,
  input wire logic [1:0] i_dummy_count_field,
  input wire logic [4:0] i_block_protect_bits,
  output logic [23:0] o_mem_rd_addr,
  input wire logic [7:0] i_mem_rd_data,
  output mem_wr_t o_mem_wr,
  output logic o_write_latch_armed,
  output logic o_write_in_progress_flag,
  output logic [7:0] o_continuous_read_bits,
  output logic [2:0] o_wrap_setting_bits
);

  localparam int unsigned PROG_CYCLES = (PROG_TIME * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  pin_set_t pins;
  logic cs_q;
  logic sclk_q;
  cmd_state_t state;
  logic [5:0] cnt;
  logic [5:0] len;
  logic [2:0] lane_w;
  logic [31:0] sh;
  logic [23:0] addr;
  logic [7:0] cur_op;
  logic [7:0] cont_op;
  read_cfg_t cfg;
  logic [7:0] out_sh;
  logic [1:0] out_cnt;
  logic has_byte;
  logic prog_clear;
  logic prog_store;
  logic [7:0] prog_col;
  logic [7:0] prog_byte;
  logic prog_start;
  logic busy;
  logic done;

  pin_sampler u_pins (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_pins('{cs_n: i_cs_n, sclk: i_sclk, io: i_io_in}),
    .o_pins(pins)
  );

  page_program_engine #(
    .PROG_CYCLES(PROG_CYCLES)
  ) u_prog (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_clear(prog_clear),
    .i_store(prog_store),
    .i_col(prog_col),
    .i_byte(prog_byte),
    .i_start(prog_start),
    .i_page(addr[23:8]),
    .o_busy(busy),
    .o_done(done),
    .o_mem_wr(o_mem_wr)
  );

  // serial edges as seen after synchronisation
  wire sclk_rise = pins.sclk && !sclk_q && !pins.cs_n;
  wire sclk_fall = !pins.sclk && sclk_q && !pins.cs_n;
  wire cs_fall = !pins.cs_n && cs_q;
  wire cs_rise = pins.cs_n && !cs_q;

  // shift and phase bookkeeping
  wire [31:0] next_sh = shift_in(sh, pins.io, lane_w);
  wire last_clk = (cnt == len - 6'h01);
  wire [5:0] next_cnt = last_clk ? 6'h00 : cnt + 6'h01;
  wire [2:0] cmd_w = i_four_line_command_mode ? LANE4 : LANE1;
  wire [7:0] op = next_sh[7:0];
  wire read_cfg_t op_cfg = read_config(op, i_four_line_command_mode, i_dummy_count_field);
  wire read_cfg_t cont_cfg = read_config(cont_op, i_four_line_command_mode, i_dummy_count_field);

  // opcode classes
  wire op_is_read = (op == OP_DUAL_OUT_READ) || (op == OP_QUAD_OUT_READ) ||
                    (op == OP_DUAL_IO_READ) || (op == OP_QUAD_IO_READ);
  wire op_needs_qe = (op == OP_QUAD_OUT_READ) || (op == OP_QUAD_IO_READ);
  wire op_lane_ok = !i_four_line_command_mode || (op == OP_QUAD_IO_READ);
  wire read_ok = op_is_read && op_lane_ok && !(op_needs_qe && !i_quad_io_enable);
  wire op_is_io_read = (op == OP_DUAL_IO_READ) || (op == OP_QUAD_IO_READ);
  wire cont_active = (o_continuous_read_bits[5:4] == CONT_KEEP_CODE);

  // wrap applies only to single-line-command quad address/data reads
  wire wrap_on = !o_wrap_setting_bits[WRAP_DISABLE_POS] && (cur_op == OP_QUAD_IO_READ) &&
                 !i_four_line_command_mode;
  wire [23:0] step_addr = next_read_addr(addr, wrap_on, o_wrap_setting_bits[2:1]);
  wire [5:0] out_clocks = byte_clocks(cfg.out_w);
  wire out_first = (out_cnt == 2'h0);
  wire [7:0] out_byte = out_first ? i_mem_rd_data : out_sh;
  wire [7:0] out_rest = (cfg.out_w == LANE4) ? {out_byte[3:0], 4'h0} : {out_byte[5:0], 2'h0};
  wire [3:0] out_bits = (cfg.out_w == LANE4) ? out_byte[7:4] : {2'h0, out_byte[7:6]};
  wire [3:0] out_oe = (cfg.out_w == LANE4) ? 4'hf : 4'h3;
  wire [1:0] out_cnt_next = (6'(out_cnt) == out_clocks - 6'h01) ? 2'h0 : out_cnt + 2'h1;

  // program commit conditions at chip select rise
  wire byte_boundary = (state == ST_PROG) && (cnt == 6'h00) && has_byte;
  wire page_locked = page_protected(addr[19:16], i_block_protect_bits);
  wire next_prog_start = cs_rise && byte_boundary && !page_locked && o_write_latch_armed;

  // after the address/mode phases, the next phase of a read
  wire [3:0] post_mode_dummy = cfg.dummy_len;
  wire to_dummy = (post_mode_dummy != 4'h0);

  assign o_mem_rd_addr = addr;
  assign o_write_in_progress_flag = busy;

  // edge history of the synchronised pins
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      cs_q <= 1'b1;
      sclk_q <= 1'b0;
    end else begin
      cs_q <= pins.cs_n;
      sclk_q <= pins.sclk;
    end
  end

  // write latch: armed by its opcode, cleared near the end of a program cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_write_latch_armed <= 1'b0;
    end else if (sclk_rise && state == ST_CMD && last_clk && op == OP_WRITE_ENABLE && !busy) begin
      o_write_latch_armed <= 1'b1;
    end else if (done) begin
      o_write_latch_armed <= 1'b0;
    end
  end

  // page buffer strobes toward the program engine
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      prog_clear <= 1'b0;
      prog_store <= 1'b0;
      prog_col <= '0;
      prog_byte <= '0;
      prog_start <= 1'b0;
      has_byte <= 1'b0;
    end else begin
      prog_clear <= 1'b0;
      prog_store <= 1'b0;
      prog_start <= next_prog_start;
      if (sclk_rise && state == ST_ADDR && last_clk && cur_op == OP_PAGE_PROGRAM) begin
        prog_clear <= 1'b1;
        prog_col <= next_sh[7:0];
        has_byte <= 1'b0;
      end else if (sclk_rise && state == ST_PROG && last_clk) begin
        prog_store <= 1'b1;
        prog_byte <= next_sh[7:0];
        has_byte <= 1'b1;
      end else if (prog_store) begin
        prog_col <= prog_col + 8'h01;
      end
    end
  end

  // command sequencer: frame start, serial rises, output on serial falls
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      cnt <= '0;
      len <= 6'h08;
      lane_w <= LANE1;
      sh <= '0;
      addr <= '0;
      cur_op <= '0;
      cont_op <= '0;
      cfg <= '0;
      out_sh <= '0;
      out_cnt <= '0;
      o_io_out <= '0;
      o_io_oe <= '0;
      o_continuous_read_bits <= CONT_BITS_RESET;
      o_wrap_setting_bits <= WRAP_SETTING_RESET;
    end else if (cs_rise || pins.cs_n) begin
      if (cs_rise && state == ST_ADDR) begin
        o_continuous_read_bits <= CONT_BITS_RESET;
      end
      state <= ST_IDLE;
      o_io_oe <= 4'h0;
      cnt <= '0;
    end else if (cs_fall) begin
      cnt <= '0;
      out_cnt <= '0;
      if (busy) begin
        state <= ST_SKIP;
      end else if (cont_active) begin
        state <= ST_ADDR;
        cur_op <= cont_op;
        cfg <= cont_cfg;
        lane_w <= cont_cfg.addr_w;
        len <= addr_clocks(cont_cfg.addr_w);
      end else begin
        state <= ST_CMD;
        lane_w <= cmd_w;
        len <= byte_clocks(cmd_w);
      end
    end else if (sclk_rise) begin
      sh <= next_sh;
      cnt <= next_cnt;
      unique case (state)
        ST_CMD: begin
          if (last_clk) begin
            cur_op <= op;
            if (busy) begin
              state <= ST_SKIP;
            end else if (read_ok) begin
              state <= ST_ADDR;
              cfg <= op_cfg;
              lane_w <= op_cfg.addr_w;
              len <= addr_clocks(op_cfg.addr_w);
              if (op_is_io_read) begin
                cont_op <= op;
              end
            end else if (op == OP_PAGE_PROGRAM && o_write_latch_armed) begin
              state <= ST_ADDR;
              len <= addr_clocks(cmd_w);
            end else if (op == OP_SET_WRAP) begin
              state <= ST_WRAP;
              len <= 6'(byte_clocks(cmd_w) * 6'd4);
            end else if (op == OP_CONT_READ_RESET) begin
              o_continuous_read_bits <= CONT_BITS_RESET;
              state <= ST_SKIP;
            end else begin
              state <= ST_SKIP;
            end
          end
        end
        ST_ADDR: begin
          if (last_clk) begin
            addr <= next_sh[23:0];
            if (cur_op == OP_PAGE_PROGRAM) begin
              state <= ST_PROG;
              len <= byte_clocks(lane_w);
            end else if (cfg.mode_len != 4'h0) begin
              state <= ST_MODE;
              len <= 6'(cfg.mode_len);
            end else begin
              state <= to_dummy ? ST_DUMMY : ST_OUT;
              len <= 6'(post_mode_dummy);
            end
          end
        end
        ST_MODE: begin
          if (last_clk) begin
            o_continuous_read_bits <= next_sh[7:0];
            state <= to_dummy ? ST_DUMMY : ST_OUT;
            len <= 6'(post_mode_dummy);
          end
        end
        ST_DUMMY: begin
          if (last_clk) begin
            state <= ST_OUT;
          end
        end
        ST_WRAP: begin
          if (last_clk) begin
            o_wrap_setting_bits <= next_sh[6:4];
            state <= ST_SKIP;
          end
        end
        ST_IDLE, ST_OUT, ST_PROG, ST_SKIP: begin
        end
        default: state <= ST_SKIP;
      endcase
    end else if (sclk_fall && state == ST_OUT) begin
      o_io_out <= out_bits;
      o_io_oe <= out_oe;
      out_sh <= out_rest;
      out_cnt <= out_cnt_next;
      if (out_first) begin
        addr <= step_addr;
      end
    end
  end

endmodule : flash_cmd_engine
`default_nettype wire

// ===== verif/flash_cmd_engine_monitor.sv
// Purpose: port checks of the flash command block
// Assumes: one clock domain
// Notes: bound to every flash_cmd_engine
`timescale 1ns/1ps
`default_nettype none
module flash_cmd_engine_monitor
  import flash_cmd_pkg::*;
#(
  parameter int unsigned PROG_TIME = PROG_TIME_NS
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_cs_n,
  input wire logic i_quad_io_enable,
  input wire logic [4:0] i_block_protect_bits,
  input wire logic [3:0] o_io_oe,
  input wire mem_wr_t o_mem_wr,
  input wire logic o_write_latch_armed,
  input wire logic o_write_in_progress_flag
);
  localparam int CYC = int'(PROG_TIME * 1000 / CLK_PERIOD_PS);
  logic [19:0] busy_cnt;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rstn);
  // length of the current busy stretch
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      busy_cnt <= 20'h0;
    end else begin
      busy_cnt <= o_write_in_progress_flag ? busy_cnt + 20'h1 : 20'h0;
    end
  end
  // output lanes, latch and program cycle
  AST_OE_RELEASE: assert property (i_cs_n [*6] |-> o_io_oe == 4'h0)
    else $error("lines driven while deselected");
  AST_QUAD_GATED: assert property (o_io_oe == 4'hf |-> i_quad_io_enable)
    else $error("quad drive with quad enable clear");
  AST_LATCH_IDLE: assert property ($rose(o_write_latch_armed) |-> !o_write_in_progress_flag)
    else $error("latch set while busy");
  AST_LATCH_CLEAR: assert property ($fell(o_write_in_progress_flag) |-> !o_write_latch_armed)
    else $error("latch still set after cycle");
  AST_START_CS: assert property ($rose(o_write_in_progress_flag) |->
    i_cs_n && $past(o_write_latch_armed))
    else $error("cycle started without cs rise or latch");
  AST_WR_BUSY: assert property (o_mem_wr.en |-> o_write_in_progress_flag)
    else $error("write outside cycle");
  AST_WR_PROT: assert property (o_mem_wr.en |-> i_block_protect_bits[2:0] < 3'h5)
    else $error("write into protected area");
  AST_BUSY_LEN: assert property ($fell(o_write_in_progress_flag) |->
    busy_cnt >= CYC - 2 && busy_cnt <= CYC + 2)
    else $error("program cycle length wrong");
  COV_QUAD: cover property (o_io_oe == 4'hf);
  COV_DUAL: cover property (o_io_oe == 4'h3);
  COV_PROG: cover property ($rose(o_write_in_progress_flag));
endmodule : flash_cmd_engine_monitor
bind flash_cmd_engine flash_cmd_engine_monitor #(.PROG_TIME(PROG_TIME))
  flash_cmd_engine_monitor_i (.i_clk(i_clk), .i_rstn(i_rstn), .i_cs_n(i_cs_n),
  .i_quad_io_enable(i_quad_io_enable), .i_block_protect_bits(i_block_protect_bits),
  .o_io_oe(o_io_oe), .o_mem_wr(o_mem_wr), .o_write_latch_armed(o_write_latch_armed),
  .o_write_in_progress_flag(o_write_in_progress_flag));
`default_nettype wire

// ===== verif/flash_host_model.sv
// Purpose: host controller driving chip select, serial clock and data
// Assumes: 160 ns serial clock, mode 0, clock idle low between frames
// Notes: lanes the host leaves free carry a toggling pattern
`timescale 1ns/1ps
`default_nettype none
module flash_host_model (
  output var logic o_cs_n,
  output var logic o_sclk,
  output var logic [3:0] o_io,
  input wire logic [3:0] i_io
);
  logic [3:0] junk = 4'h5;
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_io = 4'ha;
  end
  // select or deselect with setup and gap
  task automatic frame(input bit sel);
    #40 o_cs_n = sel;
    #100;
  endtask : frame
  // n bits msb first on w lanes, data set while clock low
  task automatic xfer(input logic [31:0] v, input int n, w, input bit drv,
                      output logic [31:0] r);
    logic [3:0] m;
    logic [3:0] s;
    r = 32'h0;
    m = drv ? 4'((1 << w) - 1) : 4'h0;
    for (int i = n - w; i >= 0; i -= w) begin
      s = 4'(v >> i);
      o_io = (s & m) | (junk & ~m);
      junk = ~junk;
      #80 o_sclk = 1'b1;
      r = (r << w) | 32'(i_io & 4'((1 << w) - 1));
      #80 o_sclk = 1'b0;
    end
  endtask : xfer
endmodule : flash_host_model
`default_nettype wire

// ===== verif/serial_flash_multi_io_read_program_test.sv
// Purpose: self-checking bench of the flash command block
// Assumes: memory content is a fixed function of the address
// Notes: program time shortened to 400 cycles
`timescale 1ns/1ps
`default_nettype none
module serial_flash_multi_io_read_program_test
  import flash_cmd_pkg::*;
;
  logic i_clk, i_rstn, i_cs_n, i_sclk, i_quad_io_enable, i_four_line_command_mode;
  logic [3:0] i_io_in, o_io_out, o_io_oe, host_io;
  logic [1:0] i_dummy_count_field;
  logic [4:0] i_block_protect_bits;
  logic [23:0] o_mem_rd_addr;
  logic [7:0] i_mem_rd_data, o_continuous_read_bits;
  mem_wr_t o_mem_wr;
  logic o_write_latch_armed, o_write_in_progress_flag;
  logic [2:0] o_wrap_setting_bits;
  logic [31:0] r;
  int fails, total_checks, cyc, nwr;
  flash_cmd_engine #(.PROG_TIME(2000)) flash_cmd_engine_i (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_cs_n(i_cs_n), .i_sclk(i_sclk), .i_io_in(i_io_in), .o_io_out(o_io_out),
    .o_io_oe(o_io_oe), .i_quad_io_enable(i_quad_io_enable),
    .i_four_line_command_mode(i_four_line_command_mode),
    .i_dummy_count_field(i_dummy_count_field), .i_block_protect_bits(i_block_protect_bits),
    .o_mem_rd_addr(o_mem_rd_addr), .i_mem_rd_data(i_mem_rd_data), .o_mem_wr(o_mem_wr),
    .o_write_latch_armed(o_write_latch_armed),
    .o_write_in_progress_flag(o_write_in_progress_flag),
    .o_continuous_read_bits(o_continuous_read_bits), .o_wrap_setting_bits(o_wrap_setting_bits));
  flash_host_model flash_host_model_i (.o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_io(host_io),
    .i_io(i_io_in));
  assign i_io_in = (o_io_oe & o_io_out) | (~o_io_oe & host_io);
  always #2.5 i_clk = ~i_clk;
  function automatic logic [7:0] mem(input logic [23:0] a);
    mem = a[7:0] ^ a[15:8] ^ 8'h5a;
  endfunction : mem
  always @(negedge i_clk) i_mem_rd_data <= mem(o_mem_rd_addr);
  // timeout and program write watch
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 60000) begin
      fails++;
      give_verdict();
    end
    if (o_mem_wr.en === 1'b1) begin
      nwr++;
      if (o_mem_wr.addr === 24'h0003ff) chk(o_mem_wr.data, 8'hab);
      else chk({o_mem_wr.addr, o_mem_wr.data}, 32'h000300cd);
    end
  end
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic go(input logic [31:0] v, input int n, w);
    flash_host_model_i.xfer(v, n, w, 1'b1, r);
  endtask : go
  task automatic rd(input int n, w);
    flash_host_model_i.xfer(32'h0, n, w, 1'b0, r);
  endtask : rd
  task automatic cs(input bit v);
    flash_host_model_i.frame(v);
  endtask : cs
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : give_verdict
  task automatic t_reads();
    cs(0);
    go(8'h6b, 8, 1);
    go(24'h0012fe, 24, 1);
    go(0, 8, 1);
    rd(16, 4);
    cs(1);
    chk(r[15:0], {mem(24'h0012fe), mem(24'h0012ff)});
    cs(0);
    go(8'h3b, 8, 1);
    go(24'h0045ff, 24, 1);
    go(0, 8, 1);
    rd(16, 2);
    cs(1);
    chk(r[15:0], {mem(24'h0045ff), mem(24'h004600)});
    cs(0);
    go(8'hbb, 8, 1);
    go(24'h000777, 24, 2);
    go(0, 8, 2);
    rd(8, 2);
    cs(1);
    chk(r[7:0], mem(24'h000777));
  endtask : t_reads
  task automatic t_no_quad();
    @(negedge i_clk) i_quad_io_enable = 1'b0;
    cs(0);
    go(8'h6b, 8, 1);
    go(0, 32, 1);
    rd(8, 4);
    chk(o_io_oe, 4'h0);
    cs(1);
    @(negedge i_clk) i_quad_io_enable = 1'b1;
  endtask : t_no_quad
  task automatic t_cont();
    cs(0);
    go(8'heb, 8, 1);
    go(24'h000140, 24, 4);
    go(8'h20, 8, 4);
    go(0, 16, 4);
    rd(8, 4);
    cs(1);
    chk(r[7:0], mem(24'h000140));
    chk(o_continuous_read_bits, 8'h20);
    cs(0);
    go(24'h000233, 24, 4);
    go(8'h20, 8, 4);
    go(0, 16, 4);
    rd(8, 4);
    cs(1);
    chk(r[7:0], mem(24'h000233));
    cs(0);
    go(8'h12, 8, 4);
    cs(1);
    chk(o_continuous_read_bits, 8'h00);
  endtask : t_cont
  task automatic t_wrap();
    cs(0);
    go(8'h77, 8, 1);
    go(8'h20, 32, 1);
    cs(1);
    chk(o_wrap_setting_bits, 3'h2);
    cs(0);
    go(8'heb, 8, 1);
    go(24'h00051e, 24, 4);
    go(0, 24, 4);
    rd(24, 4);
    cs(1);
    chk(r[23:0], {mem(24'h00051e), mem(24'h00051f), mem(24'h000510)});
    cs(0);
    go(8'h77, 8, 1);
    go(8'h10, 32, 1);
    cs(1);
    chk(o_wrap_setting_bits, 3'h1);
  endtask : t_wrap
  // four-line mode read: longest dummy field, wrap armed but ignored, then opcode skip
  task automatic t_qpi();
    cs(0);
    go(8'h77, 8, 1);
    go(8'h00, 32, 1);
    cs(1);
    @(negedge i_clk) begin
      i_four_line_command_mode = 1'b1;
      i_dummy_count_field = 2'h3;
    end
    cs(0);
    go(8'heb, 8, 4);
    go(24'h00051e, 24, 4);
    go(8'h20, 8, 4);
    go(0, 24, 4);
    rd(24, 4);
    cs(1);
    chk(r[23:0], {mem(24'h00051e), mem(24'h00051f), mem(24'h000520)});
    cs(0);
    go(24'h000600, 24, 4);
    go(0, 8, 4);
    go(0, 24, 4);
    rd(8, 4);
    cs(1);
    chk(r[7:0], mem(24'h000600));
    @(negedge i_clk) begin
      i_four_line_command_mode = 1'b0;
      i_dummy_count_field = 2'h0;
    end
    cs(0);
    go(8'h77, 8, 1);
    go(8'h10, 32, 1);
    cs(1);
    chk(o_wrap_setting_bits, 3'h1);
  endtask : t_qpi
  task automatic t_prog(input logic [4:0] bp, input int bits, input int wr_exp);
    int k;
    @(negedge i_clk) i_block_protect_bits = bp;
    cs(0);
    go(8'h06, 8, 1);
    cs(1);
    chk(o_write_latch_armed, 1'b1);
    cs(0);
    go(8'h02, 8, 1);
    go(24'h0003ff, 24, 1);
    go(32'habcd, bits, 1);
    cs(1);
    k = 0;
    while (o_write_in_progress_flag !== 1'b0 && k < 1000) begin
      @(posedge i_clk);
      k++;
    end
    chk(nwr, wr_exp);
  endtask : t_prog
  initial begin
    i_clk = 1'b0;
    i_rstn = 1'b0;
    i_quad_io_enable = 1'b1;
    i_four_line_command_mode = 1'b0;
    i_dummy_count_field = 2'h0;
    i_block_protect_bits = 5'h00;
    repeat (20) @(negedge i_clk);
    i_rstn = 1'b1;
    #100;
    chk(o_wrap_setting_bits, 3'h1);
    t_reads();
    t_no_quad();
    t_cont();
    t_wrap();
    t_qpi();
    t_prog(5'h00, 16, 2);
    chk(o_write_latch_armed, 1'b0);
    t_prog(5'h00, 12, 2);
    t_prog(5'h05, 8, 2);
    give_verdict();
  end
endmodule : serial_flash_multi_io_read_program_test
`default_nettype wire
